// ---- rtl/scc_pkg.sv ----
// scc_pkg: constants and carriers for the system clock source control block
// assumes an 8-bit special-function-register port with one-cycle strobes
package scc_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] LFO_CTRL_ADDR   = 8'he3;
    localparam logic [7:0] EXT_CTRL_ADDR   = 8'hb1;
    localparam logic [7:0] CLK_SEL_ADDR    = 8'ha9;

    // ************************************************************
    // low-frequency oscillator control fields
    // ************************************************************
    localparam int LFO_EN_BIT      = 7;
    localparam int LFO_RDY_BIT     = 6;
    localparam int LFO_TRIM_HI     = 5;
    localparam int LFO_TRIM_LO     = 2;
    localparam int LFO_DIV_HI      = 1;
    localparam int LFO_DIV_LO      = 0;
    localparam logic [3:0] LFO_TRIM_RST = 4'h8;
    localparam logic [1:0] LFO_DIV_RST  = 2'h0;

    // ************************************************************
    // external oscillator control fields
    // ************************************************************
    localparam int EXT_VALID_BIT   = 7;
    localparam int EXT_MODE_HI     = 6;
    localparam int EXT_MODE_LO     = 4;
    localparam int EXT_RANGE_HI    = 2;
    localparam int EXT_RANGE_LO    = 0;

    typedef enum logic [2:0] {
        SCC_EXT_OFF     = 3'h0,
        SCC_EXT_CMOS    = 3'h2,
        SCC_EXT_CMOS_D2 = 3'h3,
        SCC_EXT_RC      = 3'h4,
        SCC_EXT_CAP     = 3'h5,
        SCC_EXT_XTAL    = 3'h6,
        SCC_EXT_XTAL_D2 = 3'h7
    } scc_ext_mode_t;

    // ************************************************************
    // clock source select codes
    // ************************************************************
    localparam logic [1:0] SRC_HFO = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_LFO = 2'h2;
    localparam logic [1:0] SRC_RSV = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int REF_CLK_HZ       = 25_000_000;
    localparam int LFO_SETTLE_US    = 100;
    localparam int LFO_SETTLE_CYC   = (LFO_SETTLE_US * (REF_CLK_HZ / 1_000_000));
    localparam int XTAL_SETTLE_US   = 1000;
    localparam int XTAL_SETTLE_CYC  = (XTAL_SETTLE_US * (REF_CLK_HZ / 1_000_000));
    localparam int SETTLE_CNT_W     = 16;

    // register bus access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scc_sfr_req_t;

    // pins taken over by the external oscillator
    typedef struct packed {
        logic p0_2_used;
        logic p0_3_used;
    } scc_pin_use_t;

endpackage

// ---- rtl/scc_clock_control.sv ----
// scc_clock_control: oscillator control registers, settle flags, divider, glitch-free mux
// assumes oscillator edges arrive as one-cycle pulses synchronous to i_ref_clk
//
// Behaviour
// R01 - low-frequency oscillator runs only while enable bit 7 is one
// R02 - read-only ready bit 6 is one once oscillator has settled
// R03 - four-bit trim in bits 5..2, zero fastest, all ones slowest
// R04 - divider bits 1..0: 00 by 8, 01 by 4, 10 by 2, 11 by 1
// R05 - crystal or resonator mode takes port 0 pins 2 and 3
// R06 - capacitor, rc or cmos mode takes only port 0 pin 3
// R07 - software makes the crossbar skip oscillator pins
// R08 - software sets oscillator pins analog, or digital for cmos clock
// R09 - software may lower range to zero after 32.768 khz settles
// R10 - software enables missing-clock detector before external source
// R11 - software follows the crystal start-up order before switching
// R12 - hardware sets crystal-valid flag once external oscillator settles
// R13 - software waits 1 ms before reading crystal-valid in crystal mode
// R14 - internal oscillator selectable right after its enabling write
// R15 - system clock runs from external oscillator only for select 01
// R16 - external oscillator keeps clocking peripherals while internal selected
// R17 - source switches on the fly only to enabled, settled sources (low-freq: taken once enabled, before ready sets)
// R18 - rc and capacitor modes need no start-up time
// R19 - select decode: 00 high-freq, 01 external, 10 low-freq, 11 reserved
// R20 - ready bit held zero while disabled, cleared when enable clears
// R21 - source change without short pulses, on old and new edges
`timescale 1ns/1ps
module scc_clock_control
    import scc_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_nrst,
    input  wire scc_pkg::scc_sfr_req_t i_sfr,
    output logic [7:0]                o_sfr_rdata,
    input  wire logic                 i_hfo_tick,
    input  wire logic                 i_lfo_raw_tick,
    input  wire logic                 i_ext_tick,
    input  wire logic                 i_hfo_ready,
    output logic                      o_lfo_run,
    output logic [3:0]                o_lfo_trim,
    output logic                      o_ext_run,
    output logic [2:0]                o_ext_freq_range,
    output scc_pkg::scc_pin_use_t     o_pin_use,
    output logic                      o_sys_tick,
    output logic                      o_periph_ext_tick,
    output logic [1:0]                o_active_source
);
    import scc_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic                    lfo_en_reg;
    logic                    lfo_rdy_reg;
    logic [3:0]              lfo_trim_reg;
    logic [1:0]              lfo_div_reg;
    logic [SETTLE_CNT_W-1:0] lfo_cnt_reg;
    scc_ext_mode_t           ext_mode_reg;
    logic [2:0]              ext_range_reg;
    logic                    ext_valid_reg;
    logic [SETTLE_CNT_W-1:0] ext_cnt_reg;
    logic [1:0]              sel_reg;
    logic [1:0]              active_reg;
    logic [2:0]              lfo_div_cnt_reg;
    logic [7:0]              rdata_reg;
    logic                    sys_tick_reg;
    logic                    periph_tick_reg;

    logic wr_lfo;
    logic wr_ext;
    logic wr_sel;
    logic lfo_tick;
    logic ext_is_xtal;
    logic ext_on;
    logic [2:0] div_mask;
    logic new_ready;
    logic old_edge;
    logic new_edge;
    logic ext_edge;
    logic lfo_edge;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT_OLD, ST_WAIT_NEW} scc_sw_state_t;
    scc_sw_state_t sw_state_reg;

    assign wr_lfo = i_sfr.wr && (i_sfr.addr == LFO_CTRL_ADDR);
    assign wr_ext = i_sfr.wr && (i_sfr.addr == EXT_CTRL_ADDR);
    assign wr_sel = i_sfr.wr && (i_sfr.addr == CLK_SEL_ADDR);

    assign ext_on      = (ext_mode_reg != SCC_EXT_OFF);
    assign ext_is_xtal = (ext_mode_reg == SCC_EXT_XTAL) || (ext_mode_reg == SCC_EXT_XTAL_D2);

    // ************************************************************
    // low-frequency oscillator control
    // ************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            lfo_en_reg   <= 1'b0;
            lfo_trim_reg <= LFO_TRIM_RST;
            lfo_div_reg  <= LFO_DIV_RST;
        end else if (wr_lfo) begin
            lfo_en_reg   <= i_sfr.wdata[LFO_EN_BIT];
            lfo_trim_reg <= i_sfr.wdata[LFO_TRIM_HI:LFO_TRIM_LO];
            lfo_div_reg  <= i_sfr.wdata[LFO_DIV_HI:LFO_DIV_LO];
        end
    end

    // R02 settle timer
    // R20 ready cleared when disabled
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !lfo_en_reg) begin
            lfo_cnt_reg <= '0;
            lfo_rdy_reg <= 1'b0;
        end else if (lfo_cnt_reg == SETTLE_CNT_W'(LFO_SETTLE_CYC - 1)) begin
            lfo_rdy_reg <= 1'b1;
        end else begin
            lfo_cnt_reg <= lfo_cnt_reg + 1'b1;
        end
    end

    // R01 run gate
    assign o_lfo_run  = lfo_en_reg;
    // R03 trim passed to analog core
    assign o_lfo_trim = lfo_trim_reg;
    assign lfo_tick   = i_lfo_raw_tick && lfo_en_reg;

    // R04 post-divider mask: 00 by 8 ... 11 by 1
    always_comb begin
        unique case (lfo_div_reg)
            2'h0: div_mask = 3'h7;
            2'h1: div_mask = 3'h3;
            2'h2: div_mask = 3'h1;
            2'h3: div_mask = 3'h0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !lfo_en_reg) begin
            lfo_div_cnt_reg <= '0;
        end else if (lfo_tick) begin
            lfo_div_cnt_reg <= lfo_div_cnt_reg + 1'b1;
        end
    end

    // ************************************************************
    // external oscillator control
    // ************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ext_mode_reg  <= SCC_EXT_OFF;
            ext_range_reg <= '0;
        end else if (wr_ext) begin
            ext_mode_reg  <= scc_ext_mode_t'(i_sfr.wdata[EXT_MODE_HI:EXT_MODE_LO]);
            ext_range_reg <= i_sfr.wdata[EXT_RANGE_HI:EXT_RANGE_LO];
        end
    end

    // R12 valid set after settling
    // R18 rc, capacitor and cmos valid at once
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !ext_on) begin
            ext_cnt_reg   <= '0;
            ext_valid_reg <= 1'b0;
        end else if (!ext_is_xtal) begin
            ext_valid_reg <= 1'b1;
        end else if (ext_cnt_reg == SETTLE_CNT_W'(XTAL_SETTLE_CYC - 1)) begin
            ext_valid_reg <= 1'b1;
        end else if (i_ext_tick) begin
            ext_cnt_reg <= ext_cnt_reg + 1'b1;
        end
    end

    assign o_ext_run        = ext_on;
    assign o_ext_freq_range = ext_range_reg;
    // R05 crystal uses both pins
    // R06 other modes except off use pin 3 only
    assign o_pin_use.p0_2_used = ext_is_xtal;
    assign o_pin_use.p0_3_used = ext_on;

    // R16 peripherals keep external clock
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            periph_tick_reg <= 1'b0;
        end else begin
            periph_tick_reg <= i_ext_tick && ext_on;
        end
    end
    assign o_periph_ext_tick = periph_tick_reg;

    // ************************************************************
    // system clock selection
    // ************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sel_reg <= SRC_HFO;
        end else if (wr_sel) begin
            sel_reg <= i_sfr.wdata[1:0];
        end
    end

    // per-source edges as plain nets so every tick input is in the sensitivity
    assign ext_edge = i_ext_tick && ext_on;
    assign lfo_edge = lfo_tick && ((lfo_div_cnt_reg & div_mask) == div_mask);

    // R19 decode of select
    // R14 low-freq usable right after its enabling write, no settle wait
    always_comb begin
        unique case (sel_reg)
            SRC_HFO: new_ready = i_hfo_ready;
            SRC_EXT: new_ready = ext_valid_reg;
            SRC_LFO: new_ready = lfo_en_reg;
            SRC_RSV: new_ready = 1'b0;
        endcase
    end

    always_comb begin
        unique case (active_reg)
            SRC_HFO: old_edge = i_hfo_tick;
            SRC_EXT: old_edge = ext_edge;
            SRC_LFO: old_edge = lfo_edge;
            SRC_RSV: old_edge = 1'b0;
        endcase
    end

    always_comb begin
        unique case (sel_reg)
            SRC_HFO: new_edge = i_hfo_tick;
            SRC_EXT: new_edge = ext_edge;
            SRC_LFO: new_edge = lfo_edge;
            SRC_RSV: new_edge = 1'b0;
        endcase
    end

    // R17 switch only to ready source
    // R21 finish on old then new edge
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sw_state_reg <= ST_RUN;
            active_reg   <= SRC_HFO;
        end else begin
            unique case (sw_state_reg)
                ST_RUN: begin
                    if (sel_reg != active_reg && new_ready) begin
                        sw_state_reg <= ST_WAIT_OLD;
                    end
                end
                ST_WAIT_OLD: begin
                    if (sel_reg == active_reg || !new_ready) begin
                        sw_state_reg <= ST_RUN;
                    end else if (old_edge) begin
                        sw_state_reg <= ST_WAIT_NEW;
                    end
                end
                ST_WAIT_NEW: begin
                    // new source lost: fall back to the old one, never stall
                    if (!new_ready) begin
                        sw_state_reg <= ST_RUN;
                    end else if (new_edge) begin
                        // R15 external only for select 01
                        active_reg   <= sel_reg;
                        sw_state_reg <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // output held quiet between old and new edge
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sys_tick_reg <= 1'b0;
        end else begin
            sys_tick_reg <= (sw_state_reg != ST_WAIT_NEW) && old_edge;
        end
    end
    assign o_sys_tick      = sys_tick_reg;
    assign o_active_source = active_reg;

    // ************************************************************
    // register read
    // ************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rdata_reg <= '0;
        end else if (i_sfr.rd) begin
            unique case (i_sfr.addr)
                // R20 ready gated by enable, no stale one after a disable
                LFO_CTRL_ADDR: rdata_reg <= {lfo_en_reg, lfo_rdy_reg && lfo_en_reg,
                                             lfo_trim_reg, lfo_div_reg};
                EXT_CTRL_ADDR: rdata_reg <= {ext_valid_reg, ext_mode_reg, 1'b0, ext_range_reg};
                CLK_SEL_ADDR:  rdata_reg <= {6'h00, sel_reg};
                default:       rdata_reg <= 8'h00;
            endcase
        end
    end
    assign o_sfr_rdata = rdata_reg;

endmodule

// ---- test/scc_clock_control_sva.sv ----
// scc_clock_control_sva: port-level checks of the clock source control block
// assumes it is bound onto scc_clock_control, one clock domain
`timescale 1ns/1ps
module scc_clock_control_sva
    import scc_pkg::*;
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    input  wire scc_pkg::scc_sfr_req_t i_sfr,
    input  wire logic [7:0]            o_sfr_rdata,
    input  wire logic                  i_lfo_raw_tick,
    input  wire logic                  i_ext_tick,
    input  wire logic                  o_lfo_run,
    input  wire logic [3:0]            o_lfo_trim,
    input  wire logic                  o_ext_run,
    input  wire scc_pkg::scc_pin_use_t o_pin_use,
    input  wire logic                  o_sys_tick,
    input  wire logic                  o_periph_ext_tick,
    input  wire logic [1:0]            o_active_source
);
    // ********************
    // properties
    // ********************
    logic wr_lfo;
    logic wr_ext;
    assign wr_lfo = i_sfr.wr && (i_sfr.addr == LFO_CTRL_ADDR);
    assign wr_ext = i_sfr.wr && (i_sfr.addr == EXT_CTRL_ADDR);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    property p_lfo_en;
        wr_lfo |=> o_lfo_run == $past(i_sfr.wdata[7]);
    endproperty
    property p_trim;
        wr_lfo |=> o_lfo_trim == $past(i_sfr.wdata[5:2]);
    endproperty
    property p_rdy_off;
        i_sfr.rd && i_sfr.addr == LFO_CTRL_ADDR |=> !o_sfr_rdata[6] || o_sfr_rdata[7];
    endproperty
    property p_xtal_pins;
        wr_ext && i_sfr.wdata[6:5] == 2'b11 |=> o_pin_use == 2'b11;
    endproperty
    property p_one_pin;
        wr_ext && i_sfr.wdata[6:4] inside {3'h2, 3'h3, 3'h4, 3'h5}
            |=> o_pin_use == 2'b01 && o_ext_run;
    endproperty
    property p_no_rsv;
        o_active_source != SRC_RSV;
    endproperty
    property p_ext_src;
        o_sys_tick && $past(o_active_source) == SRC_EXT |-> $past(i_ext_tick);
    endproperty
    property p_lfo_src;
        o_sys_tick && $past(o_active_source) == SRC_LFO |-> $past(i_lfo_raw_tick);
    endproperty
    property p_periph;
        o_periph_ext_tick |-> $past(i_ext_tick) && $past(o_ext_run);
    endproperty
    property p_lfo_sel;
        i_sfr.wr && i_sfr.addr == CLK_SEL_ADDR && i_sfr.wdata[1:0] == SRC_LFO && o_lfo_run
            |-> ##[1:100] o_active_source == SRC_LFO;
    endproperty
    a_lfo_en: assert property (p_lfo_en) else $error("lfo run differs from enable");
    a_trim: assert property (p_trim) else $error("trim output differs");
    a_rdy_off: assert property (p_rdy_off) else $error("ready while disabled");
    a_xtal_pins: assert property (p_xtal_pins) else $error("crystal pins not taken");
    a_one_pin: assert property (p_one_pin) else $error("one-pin mode pins wrong");
    a_no_rsv: assert property (p_no_rsv) else $error("reserved source active");
    a_ext_src: assert property (p_ext_src) else $error("sys tick not from ext");
    a_lfo_src: assert property (p_lfo_src) else $error("sys tick not from lfo");
    a_periph: assert property (p_periph) else $error("stray peripheral tick");
    a_lfo_sel: assert property (p_lfo_sel) else $error("lfo switch too slow");
    c_ext: cover property (o_active_source == SRC_EXT);
    c_xtal: cover property (o_pin_use == 2'b11);
    c_rdy: cover property (o_sfr_rdata[6]);
endmodule
bind scc_clock_control scc_clock_control_sva scc_clock_control_sva_i (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
    .i_lfo_raw_tick(i_lfo_raw_tick), .i_ext_tick(i_ext_tick), .o_lfo_run(o_lfo_run),
    .o_lfo_trim(o_lfo_trim), .o_ext_run(o_ext_run), .o_pin_use(o_pin_use),
    .o_sys_tick(o_sys_tick), .o_periph_ext_tick(o_periph_ext_tick),
    .o_active_source(o_active_source));

// ---- test/scc_osc_model.sv ----
// scc_osc_model: an oscillator seen as edge pulses on the reference clock
// assumes the bench sets the period live; 1 means a tick every cycle
`timescale 1ns/1ps
module scc_osc_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_run,
    input  wire logic [3:0] i_period,
    output logic            o_tick
);
    logic [3:0] cnt_reg = 4'h0;
    logic       due;
    assign due = (cnt_reg + 4'h1) >= i_period;
    // no start-up delay
    // stopped source stands still, no stray edges
    always_ff @(posedge i_ref_clk) begin
        cnt_reg <= (!i_run || due) ? 4'h0 : cnt_reg + 4'h1;
        o_tick  <= i_run && due;
    end
endmodule

// ---- test/test_scc_clock_control.sv ----
// test_scc_clock_control: self-checking bench for the clock source control block
// assumes scc_osc_model for the three oscillators and the bound checker
`timescale 1ns/1ps
module test_scc_clock_control;
    import scc_pkg::*;
    logic         i_ref_clk, i_nrst, sys_t, ext_run, lfo_run, periph_t;
    logic [2:0]   frng;
    scc_sfr_req_t i_sfr;
    logic [7:0]   rdata, rd_val;
    logic [2:0]   tick;
    logic [3:0]   trim, tr, ext_per;
    logic [2:0]   rng;
    logic [1:0]   src;
    scc_pin_use_t pins;
    int           err_total, checked, n_a, n_b, n_c, d;

    scc_clock_control scc_clock_control_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_sfr(i_sfr), .o_sfr_rdata(rdata), .i_hfo_tick(tick[0]), .i_lfo_raw_tick(tick[1]),
        .i_ext_tick(tick[2]), .i_hfo_ready(1'b1), .o_lfo_run(lfo_run), .o_lfo_trim(trim),
        .o_ext_run(ext_run), .o_ext_freq_range(frng), .o_pin_use(pins), .o_sys_tick(sys_t),
        .o_periph_ext_tick(periph_t), .o_active_source(src));
    scc_osc_model scc_osc_model_i [2:0] (.i_ref_clk(i_ref_clk),
        .i_run({ext_run, lfo_run, 1'b1}), .i_period({ext_per, 4'h2, 4'h1}), .o_tick(tick));

    // ********************
    // helpers
    // ********************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk) i_sfr <= {wr, ~wr, a, v};
        @(posedge i_ref_clk) i_sfr <= '0;
        #1 rd_val = rdata;
    endtask
    // bounded wait for the switch to land
    task automatic wait_src(input logic [1:0] exp);
        for (int k = 0; k < 200 && src !== exp; k++) @(posedge i_ref_clk);
        #1 chk("active_source", {6'h0, src}, {6'h0, exp});
    endtask
    // count sys ticks (a), one raw source (b) and peripheral ticks (c)
    task automatic count(input int n, input int which);
        n_a = 0;
        n_b = 0;
        n_c = 0;
        repeat (n) begin
            @(posedge i_ref_clk);
            #1 n_a += sys_t;
            n_b += tick[which];
            n_c += periph_t;
        end
    endtask
    task end_sim;
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (80000) @(posedge i_ref_clk);
        err_total++;
        end_sim;
    end

    // ********************
    // scenarios
    // ********************
    initial begin
        i_nrst = 1'b0;
        i_sfr = '0;
        ext_per = 4'h1;
        err_total = 0;
        checked = 0;
        void'($urandom(88237));
        repeat (4) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        sfr(0, LFO_CTRL_ADDR, 8'h00);
        chk("lfo_rst", rd_val, {2'b00, LFO_TRIM_RST, LFO_DIV_RST});
        sfr(0, 8'h55, 8'h00);
        chk("unmapped", rd_val, 8'h00);
        for (int c = 0; c < 4; c++) begin
            tr = 4'($urandom);
            if (c == 3) tr = 4'hf;
            d = 8 >> c;
            sfr(1, LFO_CTRL_ADDR, {2'b11, tr, 2'(c)});
            sfr(0, LFO_CTRL_ADDR, 8'h00);
            chk("lfo_early", rd_val, {2'b10, tr, 2'(c)});
            chk("trim", {4'h0, trim}, {4'h0, tr});
            sfr(1, CLK_SEL_ADDR, {6'h0, SRC_LFO});
            wait_src(SRC_LFO);
            count(400, 1);
            chk("lfo_div", 8'(n_a * d >= n_b - d && n_a * d <= n_b + d), 8'h01);
            repeat (LFO_SETTLE_CYC) @(posedge i_ref_clk);
            sfr(0, LFO_CTRL_ADDR, 8'h00);
            chk("lfo_ready", rd_val, {2'b11, tr, 2'(c)});
            sfr(1, CLK_SEL_ADDR, {6'h0, SRC_HFO});
            wait_src(SRC_HFO);
            sfr(1, LFO_CTRL_ADDR, {2'b01, tr, 2'(c)});
            sfr(0, LFO_CTRL_ADDR, 8'h00);
            chk("lfo_off", rd_val, {2'b00, tr, 2'(c)});
            chk("lfo_run", {7'h0, lfo_run}, 8'h00);
        end
        for (int m = 2; m < 6; m++) begin
            rng = 3'($urandom);
            sfr(1, EXT_CTRL_ADDR, {1'b0, 3'(m), 1'b0, rng});
            chk("pins_one", {6'h0, pins}, 8'h01);
        end
        sfr(1, EXT_CTRL_ADDR, 8'h00);
        // enable, wait, poll valid, then switch
        sfr(1, EXT_CTRL_ADDR, {1'b0, 3'h6, 4'h1});
        // pins to skip and set analog are those reported here
        chk("pins_xtal", {6'h0, pins}, 8'h03);
        // at least 1 ms before polling valid
        repeat (XTAL_SETTLE_CYC + 10) @(posedge i_ref_clk);
        sfr(0, EXT_CTRL_ADDR, 8'h00);
        chk("xtal_valid", rd_val, {1'b1, 3'h6, 4'h1});
        sfr(1, EXT_CTRL_ADDR, {1'b0, 3'h6, 4'h0});
        chk("freq_range", {5'h0, frng}, 8'h00);
        ext_per = 4'h3;
        // selection only after valid, standing in for the detector step
        sfr(1, CLK_SEL_ADDR, {6'h0, SRC_EXT});
        wait_src(SRC_EXT);
        count(300, 2);
        chk("ext_sys", 8'(n_a >= n_b - 1 && n_a <= n_b + 1), 8'h01);
        sfr(1, CLK_SEL_ADDR, {6'h0, SRC_RSV});
        sfr(1, CLK_SEL_ADDR, {6'h0, SRC_LFO});
        repeat (60) @(posedge i_ref_clk);
        #1 chk("no_switch", {6'h0, src}, {6'h0, SRC_EXT});
        sfr(0, CLK_SEL_ADDR, 8'h00);
        chk("select_rd", rd_val, {6'h0, SRC_LFO});
        sfr(1, CLK_SEL_ADDR, {6'h0, SRC_HFO});
        wait_src(SRC_HFO);
        count(300, 2);
        chk("periph", 8'(n_c >= n_b - 1 && n_c <= n_b + 1), 8'h01);
        end_sim;
    end
endmodule
